// File: dctm_defs.vh
/*
 constants for the dual counter/timer: register offsets, field positions,
 reset values and prescale divisors. assumes inclusion by bare name.
*/
`ifndef DCTM_DEFS_VH
`define DCTM_DEFS_VH
`define DCTM_OFF_CTRL 8'h00
`define DCTM_OFF_MODE 8'h04
`define DCTM_OFF_CLKSEL 8'h08
`define DCTM_OFF_EXTCFG 8'h0C
`define DCTM_OFF_IRQEN 8'h10
`define DCTM_OFF_A_LOW 8'h14
`define DCTM_OFF_A_HIGH 8'h18
`define DCTM_OFF_B_LOW 8'h1C
`define DCTM_OFF_B_HIGH 8'h20
`define DCTM_OFF_ACK 8'h24
`define DCTM_CTRL_B_FLAG 7
`define DCTM_CTRL_B_RUN 6
`define DCTM_CTRL_A_FLAG 5
`define DCTM_CTRL_A_RUN 4
`define DCTM_MODE_B_GATE 7
`define DCTM_MODE_B_CSEL 6
`define DCTM_MODE_A_GATE 3
`define DCTM_MODE_A_CSEL 2
`define DCTM_CLK_B_SEL 3
`define DCTM_CLK_A_SEL 2
`define DCTM_EXT_A_POL 3
`define DCTM_EXT_B_POL 7
`define DCTM_RST_BYTE 8'h00
`define DCTM_MODE_13 2'h0
`define DCTM_MODE_16 2'h1
`define DCTM_MODE_RELOAD 2'h2
`define DCTM_MODE_SPLIT 2'h3
`define DCTM_DIV12 6'h0C
`define DCTM_DIV4 6'h04
`define DCTM_DIV48 6'h30
`define DCTM_DIV8 6'h08
`endif

// File: dctm_timers.v
/*
 two 16-bit counter/timers with 13-bit, 16-bit and 8-bit reload modes, and a split mode for timer a only (timer b holds in mode 3),
 behind an ahb-lite slave. assumes count, gate and ext clock inputs are
 synchronous to sys_clk and a single-word master.
*/
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "dctm_defs.vh"
module dctm_timers (
  input wire sys_clk,
  input wire rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire timer_a_count_pin,
  input wire timer_b_count_pin,
  input wire gate_input_a,
  input wire gate_input_b,
  input wire ext_clk,
  output reg timer_a_irq,
  output reg timer_b_irq,
  output reg timer_b_overflow_pulse
);
  reg [7:0] timer_control_status_reg_q;
  reg [7:0] timer_mode_reg_q;
  reg [7:0] timer_clock_select_reg_q;
  reg [7:0] ext_irq_config_reg_q;
  reg [1:0] irq_en_q;
  reg [7:0] timer_a_low_byte_q;
  reg [7:0] timer_a_high_byte_q;
  reg [7:0] timer_b_low_byte_q;
  reg [7:0] timer_b_high_byte_q;
  reg [7:0] addr_q;
  reg wr_q;
  reg [5:0] pre_cnt_q;
  reg pre_tick_q;
  reg [2:0] ext_div_q;
  reg ext_prev_q;
  reg pin_a_prev_q;
  reg pin_b_prev_q;
  reg [1:0] vec_ack_q;

  // falling edge between two successive samples
  function fell;
    input prev;
    input cur;
    begin
      fell = prev & ~cur;
    end
  endfunction

  // write strobe for one register offset
  function wr_hit;
    input [7:0] off;
    begin
      wr_hit = wr_q && (addr_q == off);
    end
  endfunction

  wire [1:0] mode_a = timer_mode_reg_q[1:0];
  wire [1:0] mode_b = timer_mode_reg_q[5:4];
  wire split_a = (mode_a == `DCTM_MODE_SPLIT);
  wire run_a = timer_control_status_reg_q[`DCTM_CTRL_A_RUN];
  wire run_b = timer_control_status_reg_q[`DCTM_CTRL_B_RUN];
  wire gate_a_act = gate_input_a == ext_irq_config_reg_q[`DCTM_EXT_A_POL];
  wire gate_b_act = gate_input_b == ext_irq_config_reg_q[`DCTM_EXT_B_POL];
  wire fall_a = fell(pin_a_prev_q, timer_a_count_pin);
  wire fall_b = fell(pin_b_prev_q, timer_b_count_pin);
  wire int_a = timer_clock_select_reg_q[`DCTM_CLK_A_SEL] | pre_tick_q;
  wire int_b = timer_clock_select_reg_q[`DCTM_CLK_B_SEL] | pre_tick_q;
  // count enable per timer, gated by run and gate
  wire en_a = run_a & (~timer_mode_reg_q[`DCTM_MODE_A_GATE] | gate_a_act);
  wire en_b_nominal = run_b & (~timer_mode_reg_q[`DCTM_MODE_B_GATE] | gate_b_act);
  // in split mode b runs from mode alone and never uses ext edges
  wire en_b = split_a ? 1'b1 : en_b_nominal;
  wire tick_a = en_a & (timer_mode_reg_q[`DCTM_MODE_A_CSEL] ? fall_a : int_a);
  wire tick_b_src = (timer_mode_reg_q[`DCTM_MODE_B_CSEL] & ~split_a) ? fall_b : int_b;
  wire tick_b = en_b & (mode_b != `DCTM_MODE_SPLIT) & tick_b_src;
  wire tick_ah = split_a & run_b & int_a;
  wire data_ph = hsel & hready & htrans[1];

  // one step of a timer; returns {overflow, high, low}
  function [16:0] step;
    input [1:0] mode;
    input [7:0] lo;
    input [7:0] hi;
    reg [13:0] c13;
    reg [16:0] c16;
    reg [8:0] c8;
    begin
      c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
      c16 = {1'b0, hi, lo} + 17'h00001;
      c8 = {1'b0, lo} + 9'h001;
      case (mode)
        `DCTM_MODE_13: step = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
        `DCTM_MODE_16: step = c16;
        `DCTM_MODE_RELOAD: step = {c8[8], hi, c8[8] ? hi : c8[7:0]};
        `DCTM_MODE_SPLIT: step = {c8[8], hi, c8[7:0]};
        default: step = {1'b0, hi, lo};
      endcase
    end
  endfunction

  wire [16:0] nx_a = step(mode_a, timer_a_low_byte_q, timer_a_high_byte_q);
  wire [16:0] nx_b = step(mode_b, timer_b_low_byte_q, timer_b_high_byte_q);
  wire [8:0] nx_ah = {1'b0, timer_a_high_byte_q} + 9'h001;
  wire ovf_a = tick_a & nx_a[16];
  wire ovf_ah = tick_ah & nx_ah[8];
  wire ovf_b = tick_b & nx_b[16];
  wire set_fa = ovf_a;
  wire set_fb = split_a ? ovf_ah : ovf_b;
  wire wr = wr_q;
  wire [7:0] wd = hwdata[7:0];

  // prescaler and ext clock /8
  reg [5:0] div_sel;
  always @* begin
    case (timer_clock_select_reg_q[1:0])
      2'h0: div_sel = `DCTM_DIV12;
      2'h1: div_sel = `DCTM_DIV4;
      2'h2: div_sel = `DCTM_DIV48;
      default: div_sel = `DCTM_DIV8;
    endcase
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre_cnt_q <= 6'd0;
      pre_tick_q <= 1'b0;
      ext_div_q <= 3'd0;
      ext_prev_q <= 1'b0;
      pin_a_prev_q <= 1'b0;
      pin_b_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_clk;
      pin_a_prev_q <= timer_a_count_pin;
      pin_b_prev_q <= timer_b_count_pin;
      pre_tick_q <= 1'b0;
      if (timer_clock_select_reg_q[1:0] == 2'h3) begin
        if (ext_clk & ~ext_prev_q) begin
          ext_div_q <= ext_div_q + 3'd1;
          pre_tick_q <= (ext_div_q == 3'd7);
        end
      end else if (pre_cnt_q >= div_sel - 6'd1) begin
        pre_cnt_q <= 6'd0;
        pre_tick_q <= 1'b1;
      end else begin
        pre_cnt_q <= pre_cnt_q + 6'd1;
      end
    end
  end

  // ahb-lite slave, zero wait state
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addr_q <= 8'h00;
      wr_q <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      wr_q <= data_ph & hwrite;
      addr_q <= haddr[7:0];
      hrdata <= 32'h00000000;
      if (data_ph & ~hwrite) begin
        case (haddr[7:0])
          `DCTM_OFF_CTRL: hrdata[7:0] <= timer_control_status_reg_q;
          `DCTM_OFF_MODE: hrdata[7:0] <= timer_mode_reg_q;
          `DCTM_OFF_CLKSEL: hrdata[7:0] <= timer_clock_select_reg_q;
          `DCTM_OFF_EXTCFG: hrdata[7:0] <= ext_irq_config_reg_q;
          `DCTM_OFF_IRQEN: hrdata[1:0] <= irq_en_q;
          `DCTM_OFF_A_LOW: hrdata[7:0] <= timer_a_low_byte_q;
          `DCTM_OFF_A_HIGH: hrdata[7:0] <= timer_a_high_byte_q;
          `DCTM_OFF_B_LOW: hrdata[7:0] <= timer_b_low_byte_q;
          `DCTM_OFF_B_HIGH: hrdata[7:0] <= timer_b_high_byte_q;
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // register write strobes
  wire wr_ctrl = wr_hit(`DCTM_OFF_CTRL);
  wire wr_mode = wr_hit(`DCTM_OFF_MODE);
  wire wr_clksel = wr_hit(`DCTM_OFF_CLKSEL);
  wire wr_extcfg = wr_hit(`DCTM_OFF_EXTCFG);
  wire wr_irqen = wr_hit(`DCTM_OFF_IRQEN);
  wire wr_a_low = wr_hit(`DCTM_OFF_A_LOW);
  wire wr_a_high = wr_hit(`DCTM_OFF_A_HIGH);
  wire wr_b_low = wr_hit(`DCTM_OFF_B_LOW);
  wire wr_b_high = wr_hit(`DCTM_OFF_B_HIGH);
  wire wr_ack = wr_hit(`DCTM_OFF_ACK);

  // overflow flags; a hardware set wins over a clear in the same cycle
  reg flag_a_d;
  reg flag_b_d;
  always @* begin
    flag_a_d = timer_control_status_reg_q[`DCTM_CTRL_A_FLAG];
    flag_b_d = timer_control_status_reg_q[`DCTM_CTRL_B_FLAG];
    if (wr_ctrl) begin
      flag_a_d = wd[`DCTM_CTRL_A_FLAG];
      flag_b_d = wd[`DCTM_CTRL_B_FLAG];
    end
    if (vec_ack_q[0]) begin
      flag_a_d = 1'b0;
    end
    if (vec_ack_q[1]) begin
      flag_b_d = 1'b0;
    end
    if (set_fa) begin
      flag_a_d = 1'b1;
    end
    if (set_fb) begin
      flag_b_d = 1'b1;
    end
  end

  // registers and counters
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      timer_control_status_reg_q <= `DCTM_RST_BYTE;
      timer_mode_reg_q <= `DCTM_RST_BYTE;
      timer_clock_select_reg_q <= `DCTM_RST_BYTE;
      ext_irq_config_reg_q <= `DCTM_RST_BYTE;
      irq_en_q <= 2'b00;
      timer_a_low_byte_q <= `DCTM_RST_BYTE;
      timer_a_high_byte_q <= `DCTM_RST_BYTE;
      timer_b_low_byte_q <= `DCTM_RST_BYTE;
      timer_b_high_byte_q <= `DCTM_RST_BYTE;
      vec_ack_q <= 2'b00;
      timer_a_irq <= 1'b0;
      timer_b_irq <= 1'b0;
      timer_b_overflow_pulse <= 1'b0;
    end else begin
      vec_ack_q <= wr_ack ? wd[1:0] : 2'b00;
      timer_b_overflow_pulse <= ovf_b;
      timer_a_irq <= timer_control_status_reg_q[`DCTM_CTRL_A_FLAG] & irq_en_q[0];
      timer_b_irq <= timer_control_status_reg_q[`DCTM_CTRL_B_FLAG] & irq_en_q[1];
      if (wr_ctrl) begin
        timer_control_status_reg_q <= wd;
      end
      timer_control_status_reg_q[`DCTM_CTRL_A_FLAG] <= flag_a_d;
      timer_control_status_reg_q[`DCTM_CTRL_B_FLAG] <= flag_b_d;
      if (wr_mode) begin
        timer_mode_reg_q <= wd;
      end
      if (wr_clksel) begin
        timer_clock_select_reg_q <= wd;
      end
      if (wr_extcfg) begin
        ext_irq_config_reg_q <= wd;
      end
      if (wr_irqen) begin
        irq_en_q <= wd[1:0];
      end
      // software writes take priority over a count step
      if (wr_a_low) begin
        timer_a_low_byte_q <= wd;
      end else if (tick_a) begin
        timer_a_low_byte_q <= nx_a[7:0];
      end
      if (wr_a_high) begin
        timer_a_high_byte_q <= wd;
      end else if (tick_ah) begin
        timer_a_high_byte_q <= nx_ah[7:0];
      end else if (tick_a && !split_a) begin
        timer_a_high_byte_q <= nx_a[15:8];
      end
      if (wr_b_low) begin
        timer_b_low_byte_q <= wd;
      end else if (tick_b) begin
        timer_b_low_byte_q <= nx_b[7:0];
      end
      if (wr_b_high) begin
        timer_b_high_byte_q <= wd;
      end else if (tick_b) begin
        timer_b_high_byte_q <= nx_b[15:8];
      end
    end
  end
endmodule

// File: dctm_timers_sva.sv
/* checker for the dctm_timers bus and event outputs.
 assumes one clock domain and the bind at the foot. */
`timescale 1ns/1ps
module dctm_sva (
  input wire sys_clk,
  input wire rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire timer_a_irq,
  input wire timer_b_irq,
  input wire timer_b_overflow_pulse
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire tk = hsel && hready && htrans[1];
  property p_rdy; hreadyout; endproperty
  a_rdy: assert property (p_rdy) else $error("bus stalled");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bad response");
  property p_byte; hrdata[31:8] == 24'h0; endproperty
  a_byte: assert property (p_byte) else $error("wide read data");
  property p_idle; !$past(tk && !hwrite) |-> hrdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("stale read data");
  property p_unmap; $past(tk && haddr > 32'h24) |-> hrdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_quiet; $fell(rst) |-> (!timer_a_irq && !timer_b_irq) [*3]; endproperty
  a_quiet: assert property (p_quiet) else $error("irq after reset");
  property p_pq; $fell(rst) |-> !timer_b_overflow_pulse [*3]; endproperty
  a_pq: assert property (p_pq) else $error("pulse after reset");
  property p_off;
    tk && hwrite && haddr == 32'h10 ##1 hwdata[1:0] == 2'b00 |-> ##2 !(timer_a_irq || timer_b_irq);
  endproperty
  a_off: assert property (p_off) else $error("irq not masked");
endmodule
bind dctm_timers dctm_sva u_sva (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .timer_a_irq(timer_a_irq),
  .timer_b_irq(timer_b_irq), .timer_b_overflow_pulse(timer_b_overflow_pulse));

// File: dctm_pin_model.sv
/* far side pins: count pins, gate levels, free external clock.
 assumes the bench calls edges() and sets gate levels. */
`timescale 1ns/1ps
module dctm_pin_model (
  input wire sys_clk,
  input wire gate_a_lvl,
  input wire gate_b_lvl,
  output reg timer_a_count_pin = 1'b1,
  output reg timer_b_count_pin = 1'b1,
  output reg gate_input_a = 1'b0,
  output reg gate_input_b = 1'b0,
  output reg ext_clk = 1'b0
);
  always #7 ext_clk = ~ext_clk;
  always @(posedge sys_clk) begin
    gate_input_a <= gate_a_lvl;
    gate_input_b <= gate_b_lvl;
  end
  // each level held three clocks
  task edges(input logic [1:0] m, input int n);
    repeat (n) begin
      repeat (3) @(posedge sys_clk);
      {timer_b_count_pin, timer_a_count_pin} <= ~m;
      repeat (3) @(posedge sys_clk);
      {timer_b_count_pin, timer_a_count_pin} <= 2'b11;
    end
    repeat (4) @(posedge sys_clk);
  endtask
endmodule

// File: dual_counter_timer_modes_tb_top.sv
/* self-checking bench for dctm_timers over ahb-lite.
 assumes dctm_timers, dctm_pin_model and the checker compiled first. */
`timescale 1ns/1ps
module dual_counter_timer_modes_tb_top;
  logic sys_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, ga = 1'b0, dp = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [7:0] rv;
  logic [7:0] md [3] = '{8'h04, 8'h05, 8'h06};
  logic [7:0] hi0 [3] = '{8'hFF, 8'hFF, 8'hF0};
  logic [7:0] lo1 [3] = '{8'hE1, 8'h01, 8'hF1};
  logic [7:0] hi1 [3] = '{8'h00, 8'h00, 8'hF0};
  wire [31:0] hrdata;
  wire hreadyout, hresp, pa, pb, gia, gib, xc, irq_a, irq_b, ovf_b;
  logic [31:0] exp_q [$];
  int miscompares = 0, n_tests = 0, cyc = 0, seed = 32'hB230;
  initial forever #2.5 sys_clk = ~sys_clk;
  dctm_timers uut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .timer_a_count_pin(pa), .timer_b_count_pin(pb),
    .gate_input_a(gia), .gate_input_b(gib), .ext_clk(xc), .timer_a_irq(irq_a),
    .timer_b_irq(irq_b), .timer_b_overflow_pulse(ovf_b));
  dctm_pin_model pins (.sys_clk(sys_clk), .gate_a_lvl(ga), .gate_b_lvl(1'b0),
    .timer_a_count_pin(pa), .timer_b_count_pin(pb), .gate_input_a(gia),
    .gate_input_b(gib), .ext_clk(xc));
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask
  task results();
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // read data checked at the end of its data phase
  always @(posedge sys_clk) begin
    if (dp) chk("hrdata", hrdata, exp_q.pop_front());
    dp <= hsel && hreadyout && htrans[1] && !hwrite;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    for (int a = 0; a <= 32; a += 4) rd(a[7:0], 32'h0);
    bus(1'b1, 8'h40, 32'hFF);
    rd(8'h40, 32'h0);
    $display("test reset done");
    foreach (md[i]) begin
      bus(1'b1, 8'h04, {24'h0, md[i]});
      bus(1'b1, 8'h14, 32'hFE);
      bus(1'b1, 8'h18, {24'h0, hi0[i]});
      bus(1'b1, 8'h10, 32'h1);
      bus(1'b1, 8'h00, 32'h10);
      pins.edges(2'b01, 3);
      rd(8'h00, 32'h30);
      chk("irq_a", {31'h0, irq_a}, 32'h1);
      rd(8'h14, {24'h0, lo1[i]});
      rd(8'h18, {24'h0, hi1[i]});
      if (i == 0) bus(1'b1, 8'h24, 32'h1);
      else bus(1'b1, 8'h00, 32'h0);
      @(posedge sys_clk);
      rd(8'h00, i == 0 ? 32'h10 : 32'h0);
      @(posedge sys_clk);
      chk("irq_a", {31'h0, irq_a}, 32'h0);
      bus(1'b1, 8'h00, 32'h0);
    end
    $display("test modes done");
    bus(1'b1, 8'h04, 32'h0D);
    bus(1'b1, 8'h14, 32'h0);
    ga <= 1'b1;
    bus(1'b1, 8'h00, 32'h10);
    pins.edges(2'b01, 2);
    rd(8'h14, 32'h0);
    ga <= 1'b0;
    pins.edges(2'b01, 2);
    rd(8'h14, 32'h2);
    bus(1'b1, 8'h00, 32'h0);
    $display("test gate done");
    rv = $random(seed);
    bus(1'b1, 8'h08, 32'h04);
    bus(1'b1, 8'h18, 32'hFF);
    bus(1'b1, 8'h04, 32'h07);
    bus(1'b1, 8'h00, 32'h40);
    pins.edges(2'b10, 1);
    rd(8'h00, 32'hC0);
    bus(1'b1, 8'h04, 32'h37);
    bus(1'b1, 8'h1C, {24'h0, rv});
    pins.edges(2'b10, 2);
    rd(8'h1C, {24'h0, rv});
    bus(1'b1, 8'h10, 32'h0);
    bus(1'b1, 8'h00, 32'h0);
    repeat (3) @(posedge sys_clk);
    $display("test split done");
    results();
  end
endmodule
